// ==== hw/ebt_timer.sv ====
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - each channel has readable writable 8-bit counter
// - counter steps only on selected source pulse
// - counter cleared by match or external reset
// - clear select: none, match A, B, edge
// - rollover FF to 00 sets wrap flag
// - reset and standby load counters with 00
// - channel 0/1 pair into one 16-bit word
// - paired word access is one indivisible transfer
// - match A compared each cycle, sets flag
// - match B compared each cycle, sets flag
// - compare suppressed while its register written
// - reset and standby load compares with FF
// - output follows match actions A and B
// - flag bits cleared by writing zero only
// - bank bit routes shared X/Y addresses
module ebt_timer
  import ebt_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           arst_n,
  // avalon-mm slave
  input  wire ebt_avm_req_s   avm_req,
  output logic [31:0]         avm_readdata,
  output logic                avm_waitrequest,
  // pins
  input  wire logic [NCH-1:0] ext_tick,
  input  wire logic [NCH-1:0] ext_clr,
  input  wire logic           hw_standby,
  output logic [NCH-1:0]      timer_out
);

  ebt_state_s state_reg;
  ebt_state_s state_next;

  logic           acc;
  logic           take;
  logic           bank;
  logic [NCH-1:0] we_set;
  logic [NCH-1:0] we_flg;
  logic [NCH-1:0] we_ma;
  logic [NCH-1:0] we_mb;
  logic [NCH-1:0] we_cnt;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] hit_a;
  logic [NCH-1:0] hit_b;
  logic [NCH-1:0] clr;
  logic [NCH-1:0] wrap;
  logic [7:0]     wbyte [NCH];
  logic [31:0]    rd_val;

  assign acc  = avm_req.read | avm_req.write;
  assign take = avm_req.write & ~state_reg.wait_r;
  assign bank = state_reg.conn[BANK_BIT];

  function automatic logic [7:0] chan_rd(input ebt_chan_s c, input logic [7:0] a, input logic xy);
    logic [7:0] r;
    r = 8'h00;
    if (a == (xy ? OFF_SET_XY : OFF_SET_P))
      r = c.setup;
    if (a == (xy ? OFF_FLG_XY : OFF_FLG_P))
      r = {c.flg, 1'b0, c.act_b, c.act_a};
    if (a == (xy ? OFF_MA_XY : OFF_MA_P))
      r = c.ma;
    if (a == (xy ? OFF_MB_XY : OFF_MB_P))
      r = c.mb;
    if (a == (xy ? OFF_CNT_XY : OFF_CNT_P))
      r = c.cnt;
    return r;
  endfunction

  function automatic logic out_act(input logic [1:0] act, input logic cur);
    logic r;
    case (act)
      2'h1:    r = 1'b0;
      2'h2:    r = 1'b1;
      2'h3:    r = ~cur;
      default: r = cur;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // per-channel decode, source select and compare
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    localparam bit XY = (g >= 2);
    logic       lane;
    logic       rise;
    logic       fall;
    logic [1:0] csel;
    assign lane = XY ? (avm_req.byteenable[0] & (bank == (g == 3)))
                     : avm_req.byteenable[1 - (g % 2)];
    assign wbyte[g] = XY ? avm_req.writedata[7:0] : avm_req.writedata[8 * (1 - (g % 2)) +: 8];
    assign we_set[g] = take & lane & (avm_req.address == (XY ? OFF_SET_XY : OFF_SET_P));
    assign we_flg[g] = take & lane & (avm_req.address == (XY ? OFF_FLG_XY : OFF_FLG_P));
    assign we_ma[g]  = take & lane & (avm_req.address == (XY ? OFF_MA_XY : OFF_MA_P));
    assign we_mb[g]  = take & lane & (avm_req.address == (XY ? OFF_MB_XY : OFF_MB_P));
    assign we_cnt[g] = take & lane & (avm_req.address == (XY ? OFF_CNT_XY : OFF_CNT_P));
    assign rise = state_reg.tk_s2[g] & ~state_reg.tk_d[g];
    assign fall = ~state_reg.tk_s2[g] & state_reg.tk_d[g];
    always_comb
    begin
      case (state_reg.ch[g].setup[SRC_LSB +: 3])
        3'h1:    tick[g] = &state_reg.presc[DIV_A_BITS-1:0];
        3'h2:    tick[g] = &state_reg.presc[DIV_B_BITS-1:0];
        3'h3:    tick[g] = &state_reg.presc[DIV_C_BITS-1:0];
        3'h5:    tick[g] = rise;
        3'h6:    tick[g] = fall;
        3'h7:    tick[g] = rise | fall;
        default: tick[g] = 1'b0;
      endcase
    end
    assign hit_a[g] = (state_reg.ch[g].cnt == state_reg.ch[g].ma) & ~we_ma[g];
    assign hit_b[g] = (state_reg.ch[g].cnt == state_reg.ch[g].mb) & ~we_mb[g];
    assign csel = state_reg.ch[g].setup[CLR_LSB +: 2];
    always_comb
    begin
      case (ebt_clr_e'(csel))
        CLR_MA:  clr[g] = hit_a[g];
        CLR_MB:  clr[g] = hit_b[g];
        CLR_EXT: clr[g] = state_reg.cl_s2[g] & ~state_reg.cl_d[g];
        default: clr[g] = 1'b0;
      endcase
    end
    assign wrap[g] = tick[g] & (state_reg.ch[g].cnt == CNT_TOP) & ~clr[g] & ~we_cnt[g];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (avm_req.address)
      OFF_SET_P, OFF_FLG_P, OFF_MA_P, OFF_MB_P, OFF_CNT_P:
        rd_val = {16'h0000, chan_rd(state_reg.ch[0], avm_req.address, 1'b0),
                  chan_rd(state_reg.ch[1], avm_req.address, 1'b0)};
      OFF_SET_XY, OFF_FLG_XY, OFF_MA_XY, OFF_MB_XY, OFF_CNT_XY:
        rd_val = {24'h00_0000, chan_rd(state_reg.ch[bank ? 3 : 2], avm_req.address, 1'b1)};
      OFF_CONN:
        rd_val = {24'h00_0000, state_reg.conn};
      OFF_SER_SET:
        rd_val = {24'h00_0000, state_reg.ser_set};
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_next = state_reg;
    state_next.presc = PRESC_W'(state_reg.presc + 1'b1);
    state_next.tk_s1 = ext_tick;
    state_next.tk_s2 = state_reg.tk_s1;
    state_next.tk_d  = state_reg.tk_s2;
    state_next.cl_s1 = ext_clr;
    state_next.cl_s2 = state_reg.cl_s1;
    state_next.cl_d  = state_reg.cl_s2;
    state_next.sb_s1 = hw_standby;
    state_next.sb_s2 = state_reg.sb_s1;
    state_next.wait_r = ~(acc & state_reg.wait_r);
    if (acc & state_reg.wait_r)
      state_next.rdata = rd_val;
    if (take & (avm_req.address == OFF_CONN) & avm_req.byteenable[0])
      state_next.conn = avm_req.writedata[7:0];
    if (take & (avm_req.address == OFF_SER_SET) & avm_req.byteenable[0])
      state_next.ser_set = avm_req.writedata[7:0];
    for (int i = 0; i < NCH; i++)
    begin
      if (we_set[i])
        state_next.ch[i].setup = wbyte[i];
      if (we_ma[i])
        state_next.ch[i].ma = wbyte[i];
      if (we_mb[i])
        state_next.ch[i].mb = wbyte[i];
      if (we_cnt[i])
        state_next.ch[i].cnt = wbyte[i];
      else if (clr[i])
        state_next.ch[i].cnt = RST_CNT;
      else if (tick[i])
        state_next.ch[i].cnt = 8'(state_reg.ch[i].cnt + 8'h01);
      if (we_flg[i])
      begin
        state_next.ch[i].flg = state_reg.ch[i].flg & wbyte[i][FLG_LSB +: 3];
        state_next.ch[i].act_a = wbyte[i][1:0];
        state_next.ch[i].act_b = wbyte[i][ACTB_LSB +: 2];
      end
      state_next.ch[i].flg = state_next.ch[i].flg | {hit_b[i], hit_a[i], wrap[i]};
      state_next.ch[i].tout = out_act(state_reg.ch[i].act_b,
                                      hit_a[i] ? out_act(state_reg.ch[i].act_a, state_reg.ch[i].tout)
                                               : state_reg.ch[i].tout) ;
      if (!hit_b[i])
        state_next.ch[i].tout = hit_a[i] ? out_act(state_reg.ch[i].act_a, state_reg.ch[i].tout)
                                         : state_reg.ch[i].tout;
      if (state_reg.sb_s2)
      begin
        state_next.ch[i] = '0;
        state_next.ch[i].setup = RST_SET;
        state_next.ch[i].cnt = RST_CNT;
        state_next.ch[i].ma = RST_MAT;
        state_next.ch[i].mb = RST_MAT;
      end
    end
    if (state_reg.sb_s2)
    begin
      state_next.conn = 8'h00;
      state_next.ser_set = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '0;
      state_reg.wait_r <= 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
        state_reg.ch[i].cnt <= RST_CNT;
        state_reg.ch[i].ma <= RST_MAT;
        state_reg.ch[i].mb <= RST_MAT;
      end
    end
    else
      state_reg <= state_next;
  end

  assign avm_readdata    = state_reg.rdata;
  assign avm_waitrequest = state_reg.wait_r;
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      timer_out[i] = state_reg.ch[i].tout;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_bus_answer: assert property (acc && state_reg.wait_r |=> !avm_waitrequest)
    else $error("no answer one cycle after request");
  a_bus_idle: assert property (!acc |=> avm_waitrequest)
    else $error("waitrequest low while idle");
  a_pair_read: assert property (avm_req.read && avm_waitrequest && avm_req.address == OFF_CNT_P
      && !we_cnt[0] && !we_cnt[1] ##1 avm_req.read
      |-> avm_readdata[15:0] == {$past(state_reg.ch[0].cnt), $past(state_reg.ch[1].cnt)})
    else $error("paired counter read wrong");
  a_cnt_write: assert property (we_cnt[0] && !state_reg.sb_s2 |=> state_reg.ch[0].cnt == $past(wbyte[0]))
    else $error("counter write lost");
  a_cnt_step: assert property (tick[0] && !clr[0] && !we_cnt[0] && !state_reg.sb_s2
      |=> state_reg.ch[0].cnt == 8'($past(state_reg.ch[0].cnt) + 8'h01))
    else $error("counter did not step");
  a_cnt_hold: assert property (!tick[0] && !clr[0] && !we_cnt[0] && !state_reg.sb_s2
      |=> $stable(state_reg.ch[0].cnt))
    else $error("counter moved without source pulse");
  a_clr_none: assert property (state_reg.ch[1].setup[CLR_LSB +: 2] == 2'h0 |-> !clr[1])
    else $error("clear while clearing disabled");
  a_clr_zero: assert property (clr[2] && !we_cnt[2] |=> state_reg.ch[2].cnt == RST_CNT)
    else $error("clear did not zero counter");
  a_wrap_flag: assert property (wrap[0] && !state_reg.sb_s2
      |=> state_reg.ch[0].flg[0] && state_reg.ch[0].cnt == 8'h00)
    else $error("rollover did not set wrap flag");
  a_match_a: assert property (hit_a[1] && !state_reg.sb_s2 |=> state_reg.ch[1].flg[1])
    else $error("match a flag missed");
  a_match_b: assert property (hit_b[1] && !state_reg.sb_s2 |=> state_reg.ch[1].flg[2])
    else $error("match b flag missed");
  a_cmp_quiet: assert property (we_ma[0] && !state_reg.ch[0].flg[1] && !we_flg[0]
      |=> !state_reg.ch[0].flg[1])
    else $error("compare not suppressed during write");
  a_flag_clear: assert property (we_flg[0] && !hit_a[0] && !hit_b[0] && !wrap[0] && !state_reg.sb_s2
      |=> state_reg.ch[0].flg == ($past(state_reg.ch[0].flg) & $past(wbyte[0][FLG_LSB +: 3])))
    else $error("flag write did not clear only");
  a_standby: assert property (state_reg.sb_s2
      |=> state_reg.ch[3].cnt == RST_CNT && state_reg.ch[3].ma == RST_MAT)
    else $error("standby did not initialise channel");
  a_bank_route: assert property (we_cnt[3] |-> bank && !we_cnt[2])
    else $error("bank routing wrong");

  c_wrap: cover property (wrap[0]);
  c_clr_ma: cover property (clr[0] && state_reg.ch[0].setup[CLR_LSB +: 2] == 2'h1);
  c_pair_wr: cover property (we_cnt[0] && we_cnt[1]);
  c_bank_y: cover property (we_ma[3]);

endmodule

// ==== hw/ebt_pkg.sv ====
package ebt_pkg;

  localparam int NCH = 4;

  // register byte addresses
  localparam logic [7:0] OFF_SET_P = 8'h00;
  localparam logic [7:0] OFF_FLG_P = 8'h04;
  localparam logic [7:0] OFF_MA_P  = 8'h08;
  localparam logic [7:0] OFF_MB_P  = 8'h0C;
  localparam logic [7:0] OFF_CNT_P = 8'h10;
  localparam logic [7:0] OFF_SET_XY = 8'h14;
  localparam logic [7:0] OFF_FLG_XY = 8'h18;
  localparam logic [7:0] OFF_MA_XY  = 8'h1C;
  localparam logic [7:0] OFF_MB_XY  = 8'h20;
  localparam logic [7:0] OFF_CNT_XY = 8'h24;
  localparam logic [7:0] OFF_CONN   = 8'h28;
  localparam logic [7:0] OFF_SER_SET = 8'h2C;

  // field positions
  localparam int SRC_LSB  = 0;
  localparam int CLR_LSB  = 3;
  localparam int FLG_LSB  = 5;
  localparam int ACTB_LSB = 2;
  localparam int BANK_BIT = 4;

  // reset values and counter top
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] RST_MAT = 8'hFF;
  localparam logic [7:0] RST_SET = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hFF;

  // internal clock taps, as log2 of the divide ratio
  localparam int DIV_A_BITS = 1;
  localparam int DIV_B_BITS = 3;
  localparam int DIV_C_BITS = 6;
  localparam int PRESC_W    = 7;

  typedef enum logic [1:0] {CLR_NONE, CLR_MA, CLR_MB, CLR_EXT} ebt_clr_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ebt_avm_req_s;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] cnt;
    logic [7:0] ma;
    logic [7:0] mb;
    logic [2:0] flg;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic       tout;
  } ebt_chan_s;

  typedef struct packed {
    ebt_chan_s [NCH-1:0]      ch;
    logic [7:0]               conn;
    logic [7:0]               ser_set;
    logic [PRESC_W-1:0]       presc;
    logic [NCH-1:0]           tk_s1;
    logic [NCH-1:0]           tk_s2;
    logic [NCH-1:0]           tk_d;
    logic [NCH-1:0]           cl_s1;
    logic [NCH-1:0]           cl_s2;
    logic [NCH-1:0]           cl_d;
    logic                     sb_s1;
    logic                     sb_s2;
    logic                     wait_r;
    logic [31:0]              rdata;
  } ebt_state_s;

endpackage

// ==== verif/ebt_cpu_model.sv ====
`timescale 1ns/10ps
// avalon-mm master standing for the cpu
module ebt_cpu_model
  import ebt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // avalon-mm master
  output ebt_avm_req_s     avm_req,
  input  wire logic [31:0] avm_readdata,
  input  wire logic        avm_waitrequest
);
  initial avm_req = '0;

  // one transfer: raise after an edge, hold until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avm_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
    @(posedge clk);
    while (avm_waitrequest !== 1'b0)
      @(posedge clk);
    q = avm_readdata;
    avm_req <= '0;
  endtask
endmodule

// ==== verif/eight_bit_timer_compare_core_bench.sv ====
`timescale 1ns/10ps
module eight_bit_timer_compare_core_bench
  import ebt_pkg::*;
;
  logic           clk;
  logic           arst_n;
  logic           hw_standby;
  logic [NCH-1:0] ext_tick;
  logic [NCH-1:0] ext_clr;
  logic [NCH-1:0] timer_out;
  logic [31:0]    avm_readdata;
  logic [31:0]    q;
  logic           avm_waitrequest;
  ebt_avm_req_s   avm_req;
  int             n_mismatch;
  int             n_compared;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  ebt_timer u_ebt_timer (.clk(clk), .arst_n(arst_n), .avm_req(avm_req), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .ext_tick(ext_tick), .ext_clr(ext_clr),
    .hw_standby(hw_standby), .timer_out(timer_out));
  ebt_cpu_model u_ebt_cpu_model (.clk(clk), .arst_n(arst_n), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] t;
    u_ebt_cpu_model.xfer(1'b1, a, d, be, t);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ebt_cpu_model.xfer(1'b0, a, 32'h0, 4'hF, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    rd(OFF_SET_P);  chk(q[15:0], 16'h0000);
    rd(OFF_FLG_P);  chk(q[15:0], 16'h0000);
    rd(OFF_MA_P);   chk(q[15:0], 16'hFFFF);
    rd(OFF_MB_P);   chk(q[15:0], 16'hFFFF);
    rd(OFF_CNT_P);  chk(q[15:0], 16'h0000);
    rd(OFF_CONN);   chk(q[15:0], 16'h0000);
  endtask
  task automatic pair_word;
    wr(OFF_CNT_P, 32'h0000_1234, 4'h3);
    rd(OFF_CNT_P);  chk(q[15:0], 16'h1234);
    wr(OFF_CNT_P, 32'h0000_5600, 4'h2);
    rd(OFF_CNT_P);  chk(q[15:0], 16'h5634);
    wr(8'h3C, 32'hFFFF_FFFF, 4'hF);
    rd(8'h3C);      chk(q[15:0], 16'h0000);
  endtask
  task automatic int_taps;
    wr(OFF_CNT_P, 32'h0, 4'h1);
    wr(OFF_SET_P, 32'h02, 4'h1);
    idle(61);
    wr(OFF_SET_P, 32'h03, 4'h1);
    idle(509);
    wr(OFF_SET_P, 32'h0, 4'h1);
    rd(OFF_CNT_P);  chk({8'h00, q[7:0]}, 16'h0010);
  endtask
  task automatic count_wrap;
    wr(OFF_CNT_P, 32'h0000_FE00, 4'h2);
    wr(OFF_SET_P, 32'h0000_0100, 4'h2);
    idle(20);
    wr(OFF_SET_P, 32'h0, 4'h2);
    rd(OFF_FLG_P);  chk(q[15:0], 16'hE000);
    rd(OFF_CNT_P);  chk({8'h00, q[7:0]}, 16'h0034);
    wr(OFF_FLG_P, 32'h0000_E000, 4'h2);
    rd(OFF_FLG_P);  chk(q[15:0], 16'hE000);
    wr(OFF_FLG_P, 32'h0, 4'h2);
    rd(OFF_FLG_P);  chk(q[15:0], 16'h0000);
  endtask
  task automatic clear_modes;
    logic [7:0] cv [4] = '{8'h05, 8'h05, 8'h07, 8'h30};
    logic [7:0] ev [4] = '{8'h05, 8'h00, 8'h00, 8'h00};
    wr(OFF_MA_P, 32'h0000_FF05, 4'h1);
    wr(OFF_MB_P, 32'h0000_FF07, 4'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_SET_P, 32'(i << CLR_LSB), 4'h1);
      wr(OFF_CNT_P, {24'h0, cv[i]}, 4'h1);
      ext_clr[1] <= 1'b1;
      idle(6);
      ext_clr[1] <= 1'b0;
      idle(6);
      rd(OFF_CNT_P);  chk({8'h00, q[7:0]}, {8'h00, ev[i]});
    end
    wr(OFF_SET_P, 32'h0, 4'h1);
  endtask
  task automatic out_actions;
    logic [7:0] fv [4] = '{8'h02, 8'h01, 8'h08, 8'h04};
    logic [7:0] cv [4] = '{8'h05, 8'h05, 8'h07, 8'h07};
    logic       ov [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_FLG_P, {24'h0, fv[i]}, 4'h1);
      wr(OFF_CNT_P, {24'h0, cv[i]}, 4'h1);
      idle(2);
      chk({15'h0, timer_out[1]}, {15'h0, ov[i]});
    end
    wr(OFF_FLG_P, 32'h03, 4'h1);
    wr(OFF_CNT_P, 32'h05, 4'h1);
    idle(2);
    chk({15'h0, timer_out[1]}, 16'h0001);
    idle(1);
    chk({15'h0, timer_out[1]}, 16'h0000);
  endtask
  task automatic bank_route;
    logic [7:0] ev [3] = '{8'h14, 8'h17, 8'h1D};
    wr(OFF_CONN, 32'h0, 4'h1);
    wr(OFF_CNT_XY, 32'h11, 4'h1);
    wr(OFF_CONN, 32'(1 << BANK_BIT), 4'h1);
    wr(OFF_CNT_XY, 32'h22, 4'h1);
    rd(OFF_CNT_XY); chk({8'h00, q[7:0]}, 16'h0022);
    wr(OFF_CONN, 32'h0, 4'h1);
    rd(OFF_CNT_XY); chk({8'h00, q[7:0]}, 16'h0011);
    for (int m = 0; m < 3; m++)
    begin
      wr(OFF_SET_XY, 32'(m + 5), 4'h1);
      repeat (3)
      begin
        ext_tick[2] <= 1'b1;
        idle(4);
        ext_tick[2] <= 1'b0;
        idle(4);
      end
      rd(OFF_CNT_XY); chk({8'h00, q[7:0]}, {8'h00, ev[m]});
    end
  endtask
  task automatic standby;
    wr(OFF_MA_P, 32'h0000_1234, 4'h3);
    wr(OFF_CNT_P, 32'h0000_4321, 4'h3);
    hw_standby <= 1'b1;
    idle(6);
    hw_standby <= 1'b0;
    idle(4);
    rd(OFF_MA_P);   chk(q[15:0], 16'hFFFF);
    rd(OFF_CNT_P);  chk(q[15:0], 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    hw_standby = 1'b0;
    ext_tick = '0;
    ext_clr = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    reset_values;
    pair_word;
    count_wrap;
    int_taps;
    clear_modes;
    out_actions;
    bank_route;
    standby;
    end_of_test;
  end
  initial
  begin
    #(8 * 20000);
    n_mismatch++;
    end_of_test;
  end
endmodule
